/* File: switch_cfg_defines.vh */
// constants for the switch-input configuration slice
// assumes a 100 MHz system clock and register offsets seen as 6-bit indices
//
// How it works
// - bits 0..9 of the pulse enable register switch cleaning current per input.
// - threshold bits 11:10 pick the comparator level of inputs 20..23.
// - threshold bits 9:8 pick the comparator level of inputs 16..19.
// - threshold bits 7:6 pick the comparator level of inputs 12..15.
// - threshold bits 5:4 pick the comparator level of inputs 8..11.
// - threshold bits 3:2 pick the comparator level of inputs 4..7.
// - threshold bits 1:0 pick the comparator level of inputs 0..3.
// - codes 0,1,2,3 mean 2 V, 2.7 V, 3 V and 4 V.
// - threshold register at 21h, reset zero, lowest level everywhere.
// - interrupt enable register at 22h, reset zero, no interrupts.
// - two bits per input 0..11: none, rising, falling, both edges.
// - pulse time is 64 us times code plus one, for enabled inputs.
`ifndef SWITCH_CFG_DEFINES_VH
`define SWITCH_CFG_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PULSE_TIMING_OFFSET 6'h1F
`define PULSE_ENABLE_OFFSET 6'h20
`define THRESHOLD_OFFSET 6'h21
`define IRQ_ENABLE_LOW_OFFSET 6'h22

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define PULSE_TIMING_RESET 3'h0
`define PULSE_ENABLE_RESET 24'h000000
`define THRESHOLD_RESET 12'h000
`define IRQ_ENABLE_RESET 24'h000000
`define PULSE_TIME_LSB 4
`define PULSE_TIME_MSB 6
`define THRESHOLD_MSB 11
`define PULSE_INPUTS 10

// ----------------------------------------
// edge interrupt codes
// ----------------------------------------
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 100
`define PULSE_STEP_US 64
`define PULSE_STEP_CYCLES (`PULSE_STEP_US * `CLK_MHZ)

`endif

/* File: pulse_timer.v */
// cleaning pulse timer: one window per sampling strobe
// assumes start_i is a one-cycle pulse on clk_i
`timescale 1ns/10ps
module pulse_timer #(
  parameter STEP_CYCLES = 6400,
  parameter CW = 16
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // control
  input wire start_i,
  input wire [2:0] time_code_i,
  // window
  output reg active_o
);

  reg [CW-1:0] count_q;

  // ----------------------------------------
  // window of STEP_CYCLES times code plus one
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      count_q <= {CW{1'b0}};
      active_o <= 1'b0;
    end else if (start_i) begin
      count_q <= STEP_CYCLES[CW-1:0] * ({{(CW-3){1'b0}}, time_code_i} + 1'b1) - 1'b1;
      active_o <= 1'b1;
    end else if (count_q != {CW{1'b0}}) begin
      count_q <= count_q - 1'b1;
    end else begin
      active_o <= 1'b0;
    end
  end

endmodule

/* File: edge_detect.v */
// edge event detector for comparator inputs, one event per sample
// assumes level_i is synchronised and sample_i is a one-cycle pulse
`timescale 1ns/10ps
`include "switch_cfg_defines.vh"
module edge_detect #(
  parameter N = 12
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // sampling
  input wire sample_i,
  input wire [N-1:0] level_i,
  input wire [2*N-1:0] enable_i,
  // events
  output reg [N-1:0] event_o
);

  reg [N-1:0] prev_q;
  reg seen_q;
  reg [N-1:0] event_d;
  reg [1:0] code;
  integer i;

  // ----------------------------------------
  // edge qualification per enable code
  // ----------------------------------------
  always @* begin
    event_d = {N{1'b0}};
    code = 2'h0;
    for (i = 0; i < N; i = i + 1) begin
      code = enable_i[2*i +: 2];
      if (sample_i && seen_q) begin
        if (level_i[i] && !prev_q[i]) begin
          event_d[i] = code[0];
        end else if (!level_i[i] && prev_q[i]) begin
          event_d[i] = code[1];
        end
      end
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      prev_q <= {N{1'b0}};
      seen_q <= 1'b0;
      event_o <= {N{1'b0}};
    end else begin
      event_o <= event_d;
      if (sample_i) begin
        prev_q <= level_i;
        seen_q <= 1'b1;
      end
    end
  end

endmodule

/* File: switch_threshold_regs.v */
// configuration registers for cleaning pulse, thresholds and edge enables
// assumes an upstream serial decoder presents whole-word register accesses
`timescale 1ns/10ps
`include "switch_cfg_defines.vh"
module switch_threshold_regs #(
  parameter PULSE_STEP_CYCLES = `PULSE_STEP_CYCLES,
  parameter TIMER_WIDTH = 16
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // register access
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [5:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // polling and comparators
  input wire sample_i,
  input wire [23:0] comp_raw_i,
  // analog controls
  output reg [1:0] threshold_group0_o,
  output reg [1:0] threshold_group1_o,
  output reg [1:0] threshold_group2_o,
  output reg [1:0] threshold_group3_o,
  output reg [1:0] threshold_group4_o,
  output reg [1:0] threshold_group5_o,
  output reg [47:0] input_threshold_o,
  output reg [9:0] cleaning_pulse_o,
  // status
  output reg [23:0] comp_level_o,
  output reg [11:0] comp_event_o
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function hit;
    input [5:0] addr;
    input [5:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // group index of an input, four inputs per group
  function [2:0] group_of;
    input [4:0] idx;
    begin
      group_of = idx[4:2];
    end
  endfunction

  // ----------------------------------------
  // software-visible registers
  // ----------------------------------------
  reg [2:0] pulse_duration_select_q;
  reg [23:0] cleaning_pulse_enable_reg_q;
  reg [11:0] threshold_select_reg_q;
  reg [23:0] edge_irq_enable_low_reg_q;

  // ----------------------------------------
  // applied copies, loaded at sampling
  // ----------------------------------------
  reg [2:0] pulse_time_act_q;
  reg [9:0] pulse_enable_act_q;
  reg [11:0] threshold_act_q;
  reg [23:0] irq_enable_act_q;

  // ----------------------------------------
  // synchroniser and misc
  // ----------------------------------------
  reg [23:0] comp_meta_q;
  reg [23:0] comp_sync_q;
  reg [31:0] rdata_d;
  reg [47:0] input_threshold_d;
  reg [9:0] pulse_d;
  wire pulse_window;
  wire [11:0] event_w;
  integer k;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      pulse_duration_select_q <= `PULSE_TIMING_RESET;
      cleaning_pulse_enable_reg_q <= `PULSE_ENABLE_RESET;
      threshold_select_reg_q <= `THRESHOLD_RESET;
      edge_irq_enable_low_reg_q <= `IRQ_ENABLE_RESET;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, `PULSE_TIMING_OFFSET)) begin
        pulse_duration_select_q <= reg_wdata_i[`PULSE_TIME_MSB:`PULSE_TIME_LSB];
      end
      if (hit(reg_addr_i, `PULSE_ENABLE_OFFSET)) begin
        cleaning_pulse_enable_reg_q <= reg_wdata_i[23:0];
      end
      if (hit(reg_addr_i, `THRESHOLD_OFFSET)) begin
        // upper bits dropped on write
        threshold_select_reg_q <= reg_wdata_i[`THRESHOLD_MSB:0];
      end
      if (hit(reg_addr_i, `IRQ_ENABLE_LOW_OFFSET)) begin
        edge_irq_enable_low_reg_q <= reg_wdata_i[23:0];
      end
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @* begin
    rdata_d = 32'h00000000;
    if (hit(reg_addr_i, `PULSE_TIMING_OFFSET)) begin
      rdata_d[`PULSE_TIME_MSB:`PULSE_TIME_LSB] = pulse_duration_select_q;
    end else if (hit(reg_addr_i, `PULSE_ENABLE_OFFSET)) begin
      rdata_d[23:0] = cleaning_pulse_enable_reg_q;
    end else if (hit(reg_addr_i, `THRESHOLD_OFFSET)) begin
      // bits 31..12 stay zero
      rdata_d[`THRESHOLD_MSB:0] = threshold_select_reg_q;
    end else if (hit(reg_addr_i, `IRQ_ENABLE_LOW_OFFSET)) begin
      rdata_d[23:0] = edge_irq_enable_low_reg_q;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h00000000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

  // ----------------------------------------
  // apply settings at the sampling strobe
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      pulse_time_act_q <= `PULSE_TIMING_RESET;
      pulse_enable_act_q <= 10'h000;
      threshold_act_q <= `THRESHOLD_RESET;
      irq_enable_act_q <= `IRQ_ENABLE_RESET;
    end else if (sample_i) begin
      // a write in progress lands at the following strobe
      pulse_time_act_q <= pulse_duration_select_q;
      pulse_enable_act_q <= cleaning_pulse_enable_reg_q[`PULSE_INPUTS-1:0];
      threshold_act_q <= threshold_select_reg_q;
      irq_enable_act_q <= edge_irq_enable_low_reg_q;
    end
  end

  // ----------------------------------------
  // group thresholds
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      threshold_group0_o <= 2'h0;
      threshold_group1_o <= 2'h0;
      threshold_group2_o <= 2'h0;
      threshold_group3_o <= 2'h0;
      threshold_group4_o <= 2'h0;
      threshold_group5_o <= 2'h0;
      input_threshold_o <= 48'h000000000000;
    end else begin
      threshold_group0_o <= threshold_act_q[1:0];
      threshold_group1_o <= threshold_act_q[3:2];
      threshold_group2_o <= threshold_act_q[5:4];
      threshold_group3_o <= threshold_act_q[7:6];
      threshold_group4_o <= threshold_act_q[9:8];
      threshold_group5_o <= threshold_act_q[11:10];
      input_threshold_o <= input_threshold_d;
    end
  end

  // per-input code; 0..3 select 2, 2.7, 3 and 4 V in the comparator
  always @* begin
    input_threshold_d = 48'h000000000000;
    for (k = 0; k < 24; k = k + 1) begin
      input_threshold_d[2*k +: 2] = threshold_act_q[2*group_of(k[4:0]) +: 2];
    end
  end

  // ----------------------------------------
  // cleaning pulse drive
  // ----------------------------------------
  pulse_timer #(
    .STEP_CYCLES(PULSE_STEP_CYCLES),
    .CW(TIMER_WIDTH)
  ) u_pulse_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(sample_i),
    .time_code_i(pulse_duration_select_q),
    .active_o(pulse_window)
  );

  // enable of zero keeps the current source off
  always @* begin
    pulse_d = {`PULSE_INPUTS{pulse_window}} & pulse_enable_act_q;
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      cleaning_pulse_o <= 10'h000;
    end else begin
      cleaning_pulse_o <= pulse_d;
    end
  end

  // ----------------------------------------
  // comparator synchroniser
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      comp_meta_q <= 24'h000000;
      comp_sync_q <= 24'h000000;
    end else begin
      comp_meta_q <= comp_raw_i;
      comp_sync_q <= comp_meta_q;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      comp_level_o <= 24'h000000;
    end else if (sample_i) begin
      comp_level_o <= comp_sync_q;
    end
  end

  // ----------------------------------------
  // edge events on inputs 0..11
  // ----------------------------------------
  edge_detect #(
    .N(12)
  ) u_edge_detect (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sample_i(sample_i),
    .level_i(comp_sync_q[11:0]),
    .enable_i(edge_irq_enable_low_reg_q),
    .event_o(event_w)
  );

  always @(posedge clk_i) begin
    if (reset_i) begin
      comp_event_o <= 12'h000;
    end else begin
      comp_event_o <= event_w;
    end
  end

endmodule

/* File: switch_cfg_sva.sv */
// checker for the register port and the applied settings
// assumes a bind from the testbench top file
`timescale 1ns/10ps
module switch_cfg_sva (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // register access
  input wire reg_rd_i,
  input wire [5:0] reg_addr_i,
  input wire [31:0] reg_rdata_o,
  input wire reg_rvalid_o,
  // settings and status
  input wire sample_i,
  input wire [1:0] threshold_group0_o,
  input wire [1:0] threshold_group1_o,
  input wire [1:0] threshold_group2_o,
  input wire [1:0] threshold_group3_o,
  input wire [1:0] threshold_group4_o,
  input wire [1:0] threshold_group5_o,
  input wire [47:0] input_threshold_o,
  input wire [9:0] cleaning_pulse_o,
  input wire [11:0] comp_event_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  wire [11:0] grp;
  assign grp = {threshold_group5_o, threshold_group4_o, threshold_group3_o,
    threshold_group2_o, threshold_group1_o, threshold_group0_o};
  sequence s_read(logic [5:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_quiet;
    !sample_i [*4];
  endsequence
  property p_rvalid;
    reg_rd_i |=> reg_rvalid_o;
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("no read answer");
  property p_rvalid_once;
    !reg_rd_i |=> !reg_rvalid_o;
  endproperty
  a_rvalid_once: assert property (p_rvalid_once)
    else $error("read answer too long");
  property p_thr_rsvd;
    s_read(6'h21) |=> reg_rdata_o[31:12] == 20'h00000;
  endproperty
  a_thr_rsvd: assert property (p_thr_rsvd)
    else $error("reserved bits set");
  property p_irq_width;
    s_read(6'h22) |=> reg_rdata_o[31:24] == 8'h00;
  endproperty
  a_irq_width: assert property (p_irq_width)
    else $error("edge enable too wide");
  property p_thr_hold;
    s_quiet |-> $stable(grp);
  endproperty
  a_thr_hold: assert property (p_thr_hold)
    else $error("threshold moved");
  property p_map_low;
    input_threshold_o[23:0] == {{4{grp[5:4]}}, {4{grp[3:2]}}, {4{grp[1:0]}}};
  endproperty
  a_map_low: assert property (p_map_low)
    else $error("low map wrong");
  property p_map_high;
    input_threshold_o[47:24] == {{4{grp[11:10]}}, {4{grp[9:8]}}, {4{grp[7:6]}}};
  endproperty
  a_map_high: assert property (p_map_high)
    else $error("high map wrong");
  property p_pulse_cause;
    $rose(|cleaning_pulse_o) |-> $past(sample_i, 2);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("pulse without sample");
  property p_event_cause;
    |comp_event_o |-> $past(sample_i, 2);
  endproperty
  a_event_cause: assert property (p_event_cause)
    else $error("event without sample");
  property p_event_pulse;
    |comp_event_o && !$past(sample_i) |=> comp_event_o == 12'h000;
  endproperty
  a_event_pulse: assert property (p_event_pulse)
    else $error("event too long");
endmodule

/* File: host_model.sv */
// host side of the register port, one word per strobe
// assumes the testbench calls its tasks
`timescale 1ns/10ps
module host_model (
  // clock
  input wire logic clk_i,
  // register access
  output logic wr_o,
  output logic rd_o,
  output logic [5:0] addr_o,
  output logic [31:0] wdata_o,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i
);
  // idle bus until the first task call
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 6'h00;
    wdata_o = 32'h00000000;
  end
  task automatic write(input logic [5:0] a, input logic [31:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic read(input logic [5:0] a, output logic [31:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    d = (rvalid_i === 1'b1) ? rdata_i : 32'hX;
    rd_o = 1'b0;
    addr_o = ~a;
  endtask
endmodule

/* File: switch_input_threshold_config_tb_top.sv */
// bench for the threshold, edge enable and cleaning pulse registers
// assumes design, checker and host model compile first
`timescale 1ns/10ps
`include "switch_cfg_defines.vh"
module switch_input_threshold_config_tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sample_i = 1'b0;
  logic [23:0] comp_raw_i = 24'h000000;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [5:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic [31:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic [1:0] threshold_group0_o;
  logic [1:0] threshold_group1_o;
  logic [1:0] threshold_group2_o;
  logic [1:0] threshold_group3_o;
  logic [1:0] threshold_group4_o;
  logic [1:0] threshold_group5_o;
  logic [47:0] input_threshold_o;
  logic [9:0] cleaning_pulse_o;
  logic [23:0] comp_level_o;
  logic [11:0] comp_event_o;
  logic [11:0] ev;
  logic [31:0] rv;
  logic [47:0] exp48;
  logic [31:0] tv [2] = '{32'h0000_09E4, 32'h0000_061B};
  int failures = 0;
  int comparisons = 0;
  int n;
  // shortened pulse step so windows fit in a short run
  localparam int STEP = 4;
  always #5 clk_i = ~clk_i;
  switch_threshold_regs #(
    .PULSE_STEP_CYCLES(STEP)
  ) i_switch_threshold_regs (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .sample_i(sample_i),
    .comp_raw_i(comp_raw_i),
    .threshold_group0_o(threshold_group0_o),
    .threshold_group1_o(threshold_group1_o),
    .threshold_group2_o(threshold_group2_o),
    .threshold_group3_o(threshold_group3_o),
    .threshold_group4_o(threshold_group4_o),
    .threshold_group5_o(threshold_group5_o),
    .input_threshold_o(input_threshold_o),
    .cleaning_pulse_o(cleaning_pulse_o),
    .comp_level_o(comp_level_o),
    .comp_event_o(comp_event_o)
  );
  host_model i_host_model (.clk_i(clk_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o));
  // ----
  // checks and steps
  // ----
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t reg %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t out %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    i_host_model.read(a, rv);
    chk_reg(rv, exp);
  endtask
  task automatic strobe;
    @(negedge clk_i);
    sample_i = 1'b1;
    @(negedge clk_i);
    sample_i = 1'b0;
  endtask
  task automatic poll;
    repeat (3) @(negedge clk_i);
    strobe();
    ev = 12'h000;
    repeat (4) begin
      @(negedge clk_i);
      ev = ev | comp_event_o;
    end
    chk_out(48'(comp_level_o), 48'(comp_raw_i));
  endtask
  task automatic pulse_run(input logic [2:0] code, input logic [9:0] exp_en);
    i_host_model.write(`PULSE_TIMING_OFFSET, 32'hFFFF_FF0F | {25'h0, code, 4'h0});
    strobe();
    n = 0;
    repeat (60) begin
      @(negedge clk_i);
      if (cleaning_pulse_o !== 10'h000) begin
        n++;
        chk_out(48'(cleaning_pulse_o), 48'(exp_en));
      end
    end
    chk_out(48'(n), (exp_en == 10'h000) ? 48'h0 : 48'(STEP * (int'(code) + 1)));
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    rd_chk(`THRESHOLD_OFFSET, 32'h0);
    rd_chk(`IRQ_ENABLE_LOW_OFFSET, 32'h0);
    i_host_model.write(`IRQ_ENABLE_LOW_OFFSET, 32'hFF00_0039);
    rd_chk(`IRQ_ENABLE_LOW_OFFSET, 32'h0000_0039);
    comp_raw_i = 24'h00000F;
    poll();
    chk_out(48'(ev), 48'h0);
    comp_raw_i = 24'h000000;
    poll();
    chk_out(48'(ev), 48'h006);
    comp_raw_i = 24'h00000F;
    poll();
    chk_out(48'(ev), 48'h005);
    i_host_model.write(`THRESHOLD_OFFSET, 32'hFFFF_FFFF);
    rd_chk(`THRESHOLD_OFFSET, 32'h0000_0FFF);
    chk_out(input_threshold_o, 48'h0);
    foreach (tv[k]) begin
      i_host_model.write(`THRESHOLD_OFFSET, tv[k]);
      poll();
      for (int i = 0; i < 24; i++)
        exp48[2 * i +: 2] = tv[k][2 * (i / 4) +: 2];
      chk_out(input_threshold_o, exp48);
      chk_out(48'({threshold_group5_o, threshold_group4_o, threshold_group3_o, threshold_group2_o,
        threshold_group1_o, threshold_group0_o}), 48'(tv[k][11:0]));
    end
    i_host_model.write(6'h3F, 32'hFFFF_FFFF);
    rd_chk(6'h3F, 32'h0);
    rd_chk(`THRESHOLD_OFFSET, 32'h0000_061B);
    pulse_run(3'h0, 10'h000);
    i_host_model.write(`PULSE_ENABLE_OFFSET, 32'hFFFF_FE01);
    rd_chk(`PULSE_ENABLE_OFFSET, 32'h00FF_FE01);
    pulse_run(3'h0, 10'h201);
    pulse_run(3'h7, 10'h201);
    rd_chk(`PULSE_TIMING_OFFSET, 32'h0000_0070);
    tally_and_finish();
  end
endmodule
bind switch_threshold_regs switch_cfg_sva i_switch_cfg_sva (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o),
  .sample_i(sample_i),
  .threshold_group0_o(threshold_group0_o),
  .threshold_group1_o(threshold_group1_o),
  .threshold_group2_o(threshold_group2_o),
  .threshold_group3_o(threshold_group3_o),
  .threshold_group4_o(threshold_group4_o),
  .threshold_group5_o(threshold_group5_o),
  .input_threshold_o(input_threshold_o),
  .cleaning_pulse_o(cleaning_pulse_o),
  .comp_event_o(comp_event_o)
);
